// >>> hdl/bmc_params.svh
// Functional notes
// [RL1] Bit 4 of mode control picks sample rate: 0 is 1 kHz, 1 is 125 Hz.
// [RL2] Awake mode codes: 0 off, 1 continuous, 2 sampled, 3 continuous with wake hold.
// [RL3] Awake mode bits 3:2 and sample-rate bit are read-only, loaded from configuration.
// [RL4] Writable bits 1:0 pick the deep-sleep mode; code 3 is reserved.
// [RL5] Sample-rate bit and awake mode sit outside the write protection.
// [RL6] Read-only 3-bit threshold code from configuration; upper bits read zero.
// [RL7] Two-bit margin sets warning threshold 5, 15 or 25 percent above; resets zero.
// [RL8] Edge select bits 2:1: 0 falling below, 1 rising above, 2 either way.
// [RL9] Interrupt control bit 0 enables the warning interrupt; resets zero.
// [RL10] Warning flag bit 0 sets on the comparator event chosen by edge select.
// [RL11] Warning flag only updates while the detector is enabled, else holds; the code still takes a write-one clear while off.
// [RL12] Status bit reads 1 while supply is below the warning threshold.
// [RL13] Interrupt stays high while enable and flag are both set.
// [RL14] Warning monitor follows detector mode: off when off, sampled when sampled.
// [RL15] Sleep mode field changes only within four accesses after the unlock key.
// [RL16] Deep sleep switches detector to sleep mode; waking restores awake mode.
// [RL17] Writing one clears the flag; a same-cycle set wins.
// [RL18] Comparator input is synchronised; in sampled mode taken only at sample ticks.
`ifndef BMC_PARAMS_SVH
`define BMC_PARAMS_SVH

`define BMC_CLK_PERIOD_NS 10
`define BMC_FAST_PERIOD_NS 1000000
`define BMC_SLOW_PERIOD_NS 8000000

`define BMC_IDX_MODE 4'h0
`define BMC_IDX_LEVEL 4'h1
`define BMC_IDX_MARGIN 4'h8
`define BMC_IDX_INTCTL 4'h9
`define BMC_IDX_FLAG 4'ha
`define BMC_IDX_STATUS 4'hb
`define BMC_IDX_UNLOCK 4'hc

`define BMC_RATE_BIT 4
`define BMC_AWAKE_LSB 2
`define BMC_SLEEP_LSB 0
`define BMC_EDGE_LSB 1
`define BMC_IE_BIT 0
`define BMC_IF_BIT 0

`define BMC_MODE_OFF 2'h0
`define BMC_MODE_CONT 2'h1
`define BMC_MODE_SAMP 2'h2
`define BMC_MODE_HOLDWAKE 2'h3

`define BMC_EDGE_BELOW 2'h0
`define BMC_EDGE_ABOVE 2'h1
`define BMC_EDGE_CROSS 2'h2

`define BMC_MARGIN_RESET 2'h0
`define BMC_INTCTL_RESET 3'h0
`define BMC_UNLOCK_KEY 8'ha5
`define BMC_UNLOCK_WINDOW 3'h4

`endif

// >>> hdl/bmc_pkg.sv
package bmc_pkg;

    typedef struct packed {
        logic sample_rate;
        logic [1:0] awake_mode;
        logic [1:0] sleep_mode;
        logic [2:0] threshold;
    } bmc_nvm_t;

    typedef struct packed {
        logic [5:0] address;
        logic read;
        logic write;
        logic [3:0] byteenable;
        logic [31:0] writedata;
    } bmc_avl_req_t;

    typedef struct packed {
        logic enable;
        logic sampled;
        logic sample_rate;
        logic [2:0] threshold;
        logic [1:0] margin;
    } bmc_analog_t;

    typedef struct packed {
        logic meta;
        logic sync;
    } bmc_sync_state_t;

    typedef struct packed {
        bmc_nvm_t cfg;
        logic [1:0] margin;
        logic [1:0] edge_sel;
        logic irq_en;
        logic irq_flag;
        logic below;
        logic [2:0] unlock_left;
        logic ack;
        logic [7:0] rdata;
        logic [19:0] tick_cnt;
        logic sleep_q;
        logic hold_wake;
    } bmc_state_t;

endpackage

// >>> hdl/bmc_sync.sv
`timescale 1ns/1ps
module bmc_sync
(
    // System
    input wire logic clk,
    input wire logic rst,
    // Level in and out
    input wire logic async_in,
    output logic sync_out
);

    bmc_pkg::bmc_sync_state_t st;
    bmc_pkg::bmc_sync_state_t next_st;

    always_comb
    begin
        next_st.meta = async_in;
        next_st.sync = st.meta;
        if (rst)
        begin
            next_st = '0;
        end
    end

    always_ff @(posedge clk)
    begin
        st <= next_st;
    end

    assign sync_out = st.sync;

endmodule

// >>> hdl/bmc_top.sv
// The implementer's own choice: the Avalon-MM slave port.
`timescale 1ns/1ps
`include "bmc_params.svh"
module bmc_top
#(
    parameter int FAST_TICKS = `BMC_FAST_PERIOD_NS / `BMC_CLK_PERIOD_NS,
    parameter int SLOW_TICKS = `BMC_SLOW_PERIOD_NS / `BMC_CLK_PERIOD_NS
)
(
    // System
    input wire logic clk,
    input wire logic rst,
    // Avalon-MM slave
    input wire bmc_pkg::bmc_avl_req_t avl_req,
    output logic [31:0] avl_readdata,
    output logic avl_waitrequest,
    // Configuration loaded at reset
    input wire bmc_pkg::bmc_nvm_t nvm_cfg,
    // Power state
    input wire logic sleep_deep,
    output logic cpu_hold,
    // Analog comparators
    input wire logic warn_below_async,
    input wire logic detector_ready,
    output bmc_pkg::bmc_analog_t analog_ctl,
    output logic sample_strobe,
    // Interrupt
    output logic irq
);

    bmc_pkg::bmc_state_t st;
    bmc_pkg::bmc_state_t next_st;

    logic warn_below_sync;
    logic [3:0] reg_idx;
    logic bus_req;
    logic bus_done;
    logic wr_done;
    logic rd_done;
    logic lane0;
    logic [7:0] wbyte;
    logic [1:0] cur_mode;
    logic det_en;
    logic det_samp;
    logic tick;
    logic take_sample;
    logic new_below;
    logic warn_event;
    logic flag_clr;
    logic mode_wr_ok;
    logic [19:0] tick_last;
    logic [2:0] intctl_rst;

    bmc_sync u_sync
    (
        .clk(clk),
        .rst(rst),
        .async_in(warn_below_async),
        .sync_out(warn_below_sync)
    );

    // Bus decode: one wait cycle, then the answer
    assign reg_idx = avl_req.address[5:2];
    assign bus_req = avl_req.read | avl_req.write;
    assign bus_done = bus_req & st.ack;
    assign wr_done = bus_done & avl_req.write;
    assign rd_done = bus_done & avl_req.read;
    assign lane0 = avl_req.byteenable[0];
    assign wbyte = avl_req.writedata[7:0];

    // Detector mode for the present power state
    assign cur_mode = sleep_deep ? st.cfg.sleep_mode : st.cfg.awake_mode; // RL16
    always_comb
    begin
        det_en = 1'b0;
        det_samp = 1'b0;
        unique case (cur_mode) // RL2 RL4
            `BMC_MODE_OFF:
            begin
                det_en = 1'b0;
            end
            `BMC_MODE_CONT:
            begin
                det_en = 1'b1;
            end
            `BMC_MODE_SAMP:
            begin
                det_en = 1'b1;
                det_samp = 1'b1;
            end
            `BMC_MODE_HOLDWAKE:
            begin
                // Reserved while asleep, continuous while awake
                det_en = ~sleep_deep;
            end
        endcase
    end

    // Sample tick generator
    assign tick_last = st.cfg.sample_rate ? 20'(SLOW_TICKS - 1) : 20'(FAST_TICKS - 1); // RL1
    assign tick = (st.tick_cnt >= tick_last);
    assign intctl_rst = `BMC_INTCTL_RESET;

    // Warning monitor follows the detector mode
    assign take_sample = det_en & (~det_samp | tick); // RL14 RL18
    assign new_below = take_sample ? warn_below_sync : st.below;

    always_comb
    begin
        warn_event = 1'b0;
        if (take_sample)
        begin
            unique case (st.edge_sel) // RL8
                `BMC_EDGE_BELOW: warn_event = new_below & ~st.below;
                `BMC_EDGE_ABOVE: warn_event = ~new_below & st.below;
                `BMC_EDGE_CROSS: warn_event = new_below ^ st.below;
                default: warn_event = 1'b0;
            endcase
        end
    end

    assign flag_clr = wr_done & lane0 & (reg_idx == `BMC_IDX_FLAG) & wbyte[`BMC_IF_BIT]; // RL17
    assign mode_wr_ok = wr_done & lane0 & (reg_idx == `BMC_IDX_MODE)
        & (st.unlock_left != 3'h0); // RL15

    always_comb
    begin
        next_st = st;
        next_st.ack = bus_req & ~st.ack;
        next_st.tick_cnt = tick ? 20'h0 : st.tick_cnt + 20'h1;
        next_st.below = new_below; // RL12
        next_st.sleep_q = sleep_deep;

        // Read data is captured at the edge that ends the wait cycle
        if (bus_req & ~st.ack)
        begin
            unique case (reg_idx)
                `BMC_IDX_MODE:
                    next_st.rdata = {3'h0, st.cfg.sample_rate, st.cfg.awake_mode,
                        st.cfg.sleep_mode};
                `BMC_IDX_LEVEL: next_st.rdata = {5'h0, st.cfg.threshold}; // RL6
                `BMC_IDX_MARGIN: next_st.rdata = {6'h0, st.margin};
                `BMC_IDX_INTCTL: next_st.rdata = {5'h0, st.edge_sel, st.irq_en};
                `BMC_IDX_FLAG: next_st.rdata = {7'h0, st.irq_flag};
                `BMC_IDX_STATUS: next_st.rdata = {7'h0, st.below};
                `BMC_IDX_UNLOCK: next_st.rdata = {5'h0, st.unlock_left};
                default: next_st.rdata = 8'h0;
            endcase
        end

        // Unlock window counts accepted bus transfers
        if (bus_done && st.unlock_left != 3'h0)
        begin
            next_st.unlock_left = st.unlock_left - 3'h1;
        end
        if (wr_done && lane0 && reg_idx == `BMC_IDX_UNLOCK && wbyte == `BMC_UNLOCK_KEY)
        begin
            next_st.unlock_left = `BMC_UNLOCK_WINDOW; // RL15
        end

        // Rate and awake mode ignore bus writes
        if (mode_wr_ok)
        begin
            next_st.cfg.sleep_mode = wbyte[`BMC_SLEEP_LSB +: 2]; // RL4 RL5
            next_st.unlock_left = 3'h0;
        end
        if (wr_done && lane0 && reg_idx == `BMC_IDX_MARGIN)
        begin
            next_st.margin = wbyte[1:0]; // RL7
        end
        if (wr_done && lane0 && reg_idx == `BMC_IDX_INTCTL)
        begin
            next_st.edge_sel = wbyte[`BMC_EDGE_LSB +: 2]; // RL8
            next_st.irq_en = wbyte[`BMC_IE_BIT]; // RL9
        end

        // Set wins over clear; no set while detector is off, but a write-one clear still works
        if (flag_clr)
        begin
            next_st.irq_flag = 1'b0; // RL17
        end
        if (warn_event)
        begin
            next_st.irq_flag = 1'b1; // RL10 RL11 RL17
        end

        // Hold the processor after wake until the detector runs
        if (st.sleep_q && !sleep_deep && st.cfg.awake_mode == `BMC_MODE_HOLDWAKE)
        begin
            next_st.hold_wake = 1'b1; // RL2
        end
        else if (detector_ready)
        begin
            next_st.hold_wake = 1'b0;
        end

        if (rst)
        begin
            next_st = '0;
            next_st.cfg = nvm_cfg; // RL1 RL3 RL4 RL6
            next_st.margin = `BMC_MARGIN_RESET; // RL7
            next_st.edge_sel = intctl_rst[`BMC_EDGE_LSB +: 2];
            next_st.irq_en = intctl_rst[`BMC_IE_BIT]; // RL9
        end
    end

    always_ff @(posedge clk)
    begin
        st <= next_st;
    end

    assign avl_waitrequest = bus_req & ~st.ack;
    assign avl_readdata = {24'h0, st.rdata};
    assign irq = st.irq_en & st.irq_flag; // RL13
    assign cpu_hold = st.hold_wake;
    assign sample_strobe = det_en & det_samp & tick; // RL14
    assign analog_ctl.enable = det_en;
    assign analog_ctl.sampled = det_samp;
    assign analog_ctl.sample_rate = st.cfg.sample_rate;
    assign analog_ctl.threshold = st.cfg.threshold;
    assign analog_ctl.margin = st.margin;

    a_bus_wait_one: assert property (@(posedge clk) disable iff (rst)
        (bus_req && avl_waitrequest) |=> !avl_waitrequest || !bus_req)
        else $error("Bus answer took more than one wait cycle");

    a_flag_set_wins: assert property (@(posedge clk) disable iff (rst) // RL17
        (warn_event && flag_clr) |=> st.irq_flag)
        else $error("Flag lost when set and clear met");

    a_flag_held_off: assert property (@(posedge clk) disable iff (rst) // RL11
        (!det_en && !flag_clr) |=> $stable(st.irq_flag))
        else $error("Flag changed while detector off");

    a_awake_read_only: assert property (@(posedge clk) disable iff (rst) // RL3
        (wr_done && reg_idx == `BMC_IDX_MODE)
        |=> $stable(st.cfg.awake_mode) && $stable(st.cfg.sample_rate))
        else $error("Read-only mode bits changed by a write");

    a_sleep_locked: assert property (@(posedge clk) disable iff (rst) // RL15
        (wr_done && reg_idx == `BMC_IDX_MODE && st.unlock_left == 3'h0)
        |=> $stable(st.cfg.sleep_mode))
        else $error("Sleep mode changed without unlock");

    a_irq_persists: assert property (@(posedge clk) disable iff (rst) // RL13
        (irq && !(wr_done && (reg_idx == `BMC_IDX_FLAG || reg_idx == `BMC_IDX_INTCTL)))
        |=> irq)
        else $error("Interrupt dropped without software action");

    a_level_upper_zero: assert property (@(posedge clk) disable iff (rst) // RL6
        (rd_done && reg_idx == `BMC_IDX_LEVEL) |-> avl_readdata[31:3] == 29'h0)
        else $error("Threshold readback upper bits not zero");

    a_sampled_on_tick: assert property (@(posedge clk) disable iff (rst) // RL18
        (det_samp && !tick) |=> $stable(st.below))
        else $error("Sampled monitor changed between ticks");

    a_irq_enable_write: assert property (@(posedge clk) disable iff (rst) // RL9
        (wr_done && lane0 && reg_idx == `BMC_IDX_INTCTL) |=> st.irq_en == $past(wbyte[0]))
        else $error("Interrupt enable not taken from write");

    a_sleep_mode_used: assert property (@(posedge clk) disable iff (rst) // RL16
        (sleep_deep && st.cfg.sleep_mode == `BMC_MODE_OFF) |-> !analog_ctl.enable)
        else $error("Detector on in deep sleep with sleep mode off");

endmodule

// >>> sim/bmc_analog_model.sv
`timescale 1ns/1ps
module bmc_analog_model
(
    // System
    input wire logic clk,
    // Control from the block and supply level from the bench
    input wire bmc_pkg::bmc_analog_t analog_ctl,
    input wire logic supply_below,
    // Comparator outputs
    output logic warn_below_async,
    output logic detector_ready
);
    logic junk = 1'b0;
    always @(posedge clk)
        junk <= ~junk;
    // A powered-down comparator gives nothing useful
    assign warn_below_async = analog_ctl.enable ? supply_below : junk;
    assign detector_ready = analog_ctl.enable;
endmodule

// >>> sim/bmc_top_bench.sv
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin mismatches++; \
    $display("MISMATCH %s exp %h got %h", nm, e, g); end end
module bmc_top_bench;
    logic clk = 1'b0;
    logic rst = 1'b1;
    bmc_pkg::bmc_avl_req_t req = '0;
    bmc_pkg::bmc_nvm_t nvm = '0;
    bmc_pkg::bmc_analog_t actl;
    logic [31:0] rdata;
    logic wait_n, sleep_deep = 1'b0, below = 1'b0, warn, ready, hold, strobe, irq;
    logic [7:0] q, mode_exp;
    logic [1:0] m;
    int seed = 58;
    int mismatches = 0;
    int n_checks = 0;
    int n_strobe;
    always #5 clk = ~clk;
    bmc_top #(.FAST_TICKS(8), .SLOW_TICKS(16)) dut_u (.clk(clk), .rst(rst), .avl_req(req),
        .avl_readdata(rdata), .avl_waitrequest(wait_n), .nvm_cfg(nvm), .sleep_deep(sleep_deep),
        .cpu_hold(hold), .warn_below_async(warn), .detector_ready(ready), .analog_ctl(actl),
        .sample_strobe(strobe), .irq(irq));
    bmc_analog_model model_u (.clk(clk), .analog_ctl(actl), .supply_below(below),
        .warn_below_async(warn), .detector_ready(ready));
    task tally_and_finish();
        if (mismatches == 0 && n_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    task bus(input logic wr, input logic [3:0] idx, input logic [7:0] d);
        int n;
        logic [31:0] r;
        n = 0;
        r = $random(seed);
        @(posedge clk);
        req.address <= {idx, 2'b00};
        req.read <= ~wr;
        req.write <= wr;
        req.byteenable <= 4'h1;
        req.writedata <= {r[31:8], d};
        do
        begin
            @(posedge clk);
            n++;
        end
        while (wait_n !== 1'b0 && n < 50);
        if (n >= 50)
            mismatches++;
        q = rdata[7:0];
        req.read <= 1'b0;
        req.write <= 1'b0;
    endtask
    task rd_chk(input logic [3:0] idx, input logic [7:0] e);
        bus(1'b0, idx, 8'h00);
        `CHK("register", e, q)
    endtask
    task settle();
        repeat (5) @(posedge clk);
    endtask
    function automatic logic flag_exp(input logic [1:0] e, input logic fall);
        return fall ? (e != 2'h1) : (e != 2'h0);
    endfunction
    function automatic int strobe_exp(input logic slow);
        return 48 / (slow ? 16 : 8);
    endfunction
    initial
    begin
        repeat (20000) @(posedge clk);
        mismatches++;
        tally_and_finish();
    end
    initial
    begin
        nvm = bmc_pkg::bmc_nvm_t'(8'($random(seed)));
        nvm.awake_mode = 2'h1;
        nvm.sleep_mode = 2'h2;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        mode_exp = {3'h0, nvm.sample_rate, 2'h1, 2'h2};
        rd_chk(4'h0, mode_exp);
        rd_chk(4'h1, {5'h00, nvm.threshold});
        rd_chk(4'h8, 8'h00);
        rd_chk(4'h9, 8'h00);
        rd_chk(4'ha, 8'h00);
        rd_chk(4'h2, 8'h00);
        bus(1'b1, 4'h0, 8'hff);
        rd_chk(4'h0, mode_exp);
        bus(1'b1, 4'hc, 8'ha5);
        bus(1'b1, 4'h0, 8'hf0);
        rd_chk(4'h0, {3'h0, nvm.sample_rate, 2'h1, 2'h0});
        m = 2'($unsigned($random(seed)) % 3);
        bus(1'b1, 4'h8, {6'h3f, m});
        rd_chk(4'h8, {6'h00, m});
        `CHK("margin_out", m, actl.margin)
        for (int e = 0; e < 3; e++)
        begin
            bus(1'b1, 4'h9, {5'h00, 2'(e), 1'b1});
            below <= 1'b1;
            settle();
            rd_chk(4'hb, 8'h01);
            rd_chk(4'ha, {7'h00, flag_exp(2'(e), 1'b1)});
            `CHK("irq", flag_exp(2'(e), 1'b1), irq)
            bus(1'b1, 4'ha, 8'h01);
            rd_chk(4'ha, 8'h00);
            below <= 1'b0;
            settle();
            rd_chk(4'hb, 8'h00);
            rd_chk(4'ha, {7'h00, flag_exp(2'(e), 1'b0)});
            bus(1'b1, 4'ha, 8'hfe);
            rd_chk(4'ha, {7'h00, flag_exp(2'(e), 1'b0)});
            bus(1'b1, 4'ha, 8'h01);
        end
        bus(1'b1, 4'h9, 8'h04);
        below <= 1'b1;
        settle();
        rd_chk(4'ha, 8'h01);
        `CHK("irq_masked", 1'b0, irq)
        bus(1'b1, 4'h9, 8'h05);
        @(negedge clk);
        `CHK("irq_on", 1'b1, irq)
        bus(1'b1, 4'ha, 8'h01);
        @(negedge clk);
        `CHK("irq_off", 1'b0, irq)
        sleep_deep <= 1'b1;
        @(posedge clk);
        @(negedge clk);
        `CHK("sleep_enable", 1'b0, actl.enable)
        repeat (8) @(posedge clk);
        rd_chk(4'ha, 8'h00);
        `CHK("irq_sleep", 1'b0, irq)
        sleep_deep <= 1'b0;
        @(posedge clk);
        @(negedge clk);
        `CHK("wake_enable", 1'b1, actl.enable)
        settle();
        bus(1'b1, 4'ha, 8'h01);
        below <= 1'b0;
        settle();
        rd_chk(4'ha, 8'h01);
        `CHK("cpu_hold", 1'b0, hold)
        bus(1'b1, 4'hc, 8'ha5);
        bus(1'b1, 4'h0, 8'h02);
        sleep_deep <= 1'b1;
        @(posedge clk);
        @(negedge clk);
        `CHK("sampled", 1'b1, actl.sampled)
        n_strobe = 0;
        repeat (48)
        begin
            @(negedge clk);
            n_strobe += strobe;
        end
        `CHK("strobes", strobe_exp(nvm.sample_rate), n_strobe)
        @(posedge clk);
        sleep_deep <= 1'b0;
        tally_and_finish();
    end
endmodule
